// *** rtcr_cfg.svh ***
// constants for the clock and calendar register block
`ifndef RTCR_CFG_SVH
`define RTCR_CFG_SVH
// Behaviour
// - block every data-port access while an external bus master owns the bus; index writes still latch
// - with the secure lock active, refuse indices 38-3f only
// - decode 128 indices: 00-09 time, 0a-0d control, 0e-7f ram
// - all readable; c, d, a bit 7 and seconds bit 7 not writable
// - time, calendar and alarm bytes kept and advanced in bcd
// - 12-hour hours count 01-12 with top bit marking pm
// - update once per second; 2ms window ignores clock-byte writes
// - each update compares seconds, minutes, hours with alarm bytes
// - alarm byte with both top bits set matches any value
// - general ram never altered by the clock, accessible unless bus master or secure lock refuses it
// - control and status registers accessible at all times except while a bus master owns the bus
// - update pending rises 244us before update, holds through it
// - writing one to update halt clears update pending at once
// - register a: pending b7 read only, divider b6-b4, rate b3-b0
// - divider codes 000, 001, 010 run; other codes hold divider reset
// - index written on port 070 bits 6-0; data through port 071
// - update halt suppresses and aborts updates; clearing resumes
// - hour-format bit one means 24-hour form for both hour bytes
`define RTCR_IDX_SEC      7'h00
`define RTCR_IDX_SEC_AL   7'h01
`define RTCR_IDX_MIN      7'h02
`define RTCR_IDX_MIN_AL   7'h03
`define RTCR_IDX_HR       7'h04
`define RTCR_IDX_HR_AL    7'h05
`define RTCR_IDX_WDAY     7'h06
`define RTCR_IDX_DATE     7'h07
`define RTCR_IDX_MONTH    7'h08
`define RTCR_IDX_YEAR     7'h09
`define RTCR_IDX_REG_A    7'h0a
`define RTCR_IDX_REG_B    7'h0b
`define RTCR_IDX_REG_C    7'h0c
`define RTCR_IDX_REG_D    7'h0d
`define RTCR_IDX_RAM_LO   7'h0e
`define RTCR_IDX_SECURE_LO 7'h38
`define RTCR_IDX_SECURE_HI 7'h3f
`define RTCR_PORT_INDEX   10'h070
`define RTCR_PORT_DATA    10'h071
`define RTCR_BIT_PEND     7
`define RTCR_BIT_HALT     7
`define RTCR_BIT_H24      1
`define RTCR_BIT_PM       7
`define RTCR_DIV_4M       3'h0
`define RTCR_DIV_1M       3'h1
`define RTCR_DIV_32K      3'h2
`define RTCR_DONT_CARE    2'h3
`define RTCR_NO_DATA      8'hff
`define RTCR_CLK_HZ       40000000
`define RTCR_UPD_US       2000
`define RTCR_PEND_US      244
// both cycle counts use whole clock cycles per microsecond, truncated the same way
`define RTCR_UPD_CYC      ((`RTCR_CLK_HZ / 1000000) * `RTCR_UPD_US)
`define RTCR_PEND_CYC     ((`RTCR_CLK_HZ / 1000000) * `RTCR_PEND_US)
`endif

// *** rtcr_pkg.sv ***
// types for the clock and calendar register block
package rtcr_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_UPD} rtcr_phase_t;
	// one host cycle on the index/data port pair
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rtcr_io_t;
	// clock and calendar bytes as kept in storage
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hr;
		logic [7:0] wday;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
	} rtcr_time_t;
endpackage

// *** rtcr_core.sv ***
// clock, calendar, alarm and ram behind the index/data port pair
`timescale 1ns/1ps
`default_nettype none
`include "rtcr_cfg.svh"
module rtcr_core #(
	parameter int SEC_CYC = `RTCR_CLK_HZ,   // cycles per second tick
	parameter int UPD_CYC = `RTCR_UPD_CYC,
	parameter int PEND_CYC = `RTCR_PEND_CYC
) (
	// clock and reset
	input  wire logic           i_mclk,
	input  wire logic           i_resetn,
	// host port pair
	input  wire rtcr_pkg::rtcr_io_t i_io,
	input  wire logic           i_bus_master_n,
	input  wire logic           i_secure_area_lock,
	// answers
	output var  logic [7:0]     o_rdata,
	output var  logic           o_rvalid,
	output var  logic           o_alarm,
	output var  logic           o_update_pending_flag
);
	import rtcr_pkg::*;

	initial begin
		if (SEC_CYC <= PEND_CYC + UPD_CYC || UPD_CYC < 1 || PEND_CYC < 1)
			$error("rtcr_core: second too short for pending lead and update");
	end

	typedef struct packed {
		logic [1:0]   rst_sync;
		logic [6:0]   index;
		rtcr_time_t   tm;
		logic [7:0]   sec_al;
		logic [7:0]   min_al;
		logic [7:0]   hr_al;
		logic [6:0]   reg_a;
		logic [7:0]   reg_b;
		logic [3:0]   reg_c;
		rtcr_phase_t  phase;
		logic [31:0]  sec_cnt;
		logic [31:0]  upd_cnt;
		logic         pend;
		logic [7:0]   rdata;
		logic         rvalid;
		logic         alarm;
	} rtcr_state_t;

	rtcr_state_t s_r;
	rtcr_state_t s_nxt;
	logic [7:0]  ram_r [`RTCR_IDX_RAM_LO:127];
	logic [1:0]  rst_q_r;
	logic        rstn_int;

	// reset release through two flip-flops
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_q_r <= 2'h0;
		end else begin
			rst_q_r <= {rst_q_r[0], 1'b1};
		end
	end
	assign rstn_int = rst_q_r[1];

	// bcd increment with wrap to a given low value past a given high value
	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] hi,
	                                        input logic [7:0] lo, output logic wrap);
		logic [7:0] r;
		r = 8'h00;
		wrap = (v >= hi);
		if (wrap)
			r = lo;
		else if (v[3:0] >= 4'h9)
			r = {v[7:4] + 4'h1, 4'h0};
		else
			r = {v[7:4], v[3:0] + 4'h1};
		return r;
	endfunction

	// alarm byte match, don't-care when both top bits are set
	function automatic logic al_match(input logic [7:0] al, input logic [7:0] v);
		return (al[7:6] == `RTCR_DONT_CARE) || (al == v);
	endfunction

	// last date of a month, bcd, including leap february
	function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
		logic [7:0] d;
		d = 8'h31;
		unique case (m)
			8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
			8'h02: d = (y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			                 : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8))
			                ? 8'h29 : 8'h28;
			default: d = 8'h31;
		endcase
		return d;
	endfunction

	logic        is_clk_byte;
	logic        refused;
	logic        on_data;
	logic        div_run;
	logic [6:0]  idx;
	rtcr_time_t  t;
	logic        w0, w1, w2, w3, w4, w5;
	logic        pm;
	logic [7:0]  hv;
	logic [7:0]  rd;
	// flag bits raised by this cycle's update, kept when a read clears the rest
	logic [3:0]  flag_set;

	// one next-state process for port decode, update sequencing and flags
	// reads and writes see the registered index, so a data cycle right after
	// an index write already uses the new index
	always_comb begin
		s_nxt = s_r;
		s_nxt.rst_sync = 2'h0;
		s_nxt.rvalid = 1'b0;
		s_nxt.alarm = 1'b0;
		flag_set = 4'h0;
		idx = s_r.index;
		t = s_r.tm;
		{w0, w1, w2, w3, w4, w5} = 6'h00;
		pm = 1'b0;
		hv = 8'h00;
		rd = 8'h00;
		on_data = (i_io.addr == `RTCR_PORT_DATA);
		is_clk_byte = (idx < `RTCR_IDX_REG_A);
		// data accesses refused under a bus master, and 38-3f under the secure lock
		refused = !i_bus_master_n
		       || (i_secure_area_lock && idx >= `RTCR_IDX_SECURE_LO
		           && idx <= `RTCR_IDX_SECURE_HI);
		div_run = (s_r.reg_a[6:4] == `RTCR_DIV_4M) || (s_r.reg_a[6:4] == `RTCR_DIV_1M)
		       || (s_r.reg_a[6:4] == `RTCR_DIV_32K);

		// index latch on port 070, bits 6-0 only
		if (i_io.wr && i_io.addr == `RTCR_PORT_INDEX)
			s_nxt.index = i_io.wdata[6:0];

		// second tick and update sequencing
		if (!div_run || s_r.reg_b[`RTCR_BIT_HALT]) begin
			s_nxt.phase = ST_IDLE;
			s_nxt.pend = 1'b0;
			s_nxt.upd_cnt = 32'h0;
			if (!div_run)
				s_nxt.sec_cnt = 32'h0;
		end else begin
			s_nxt.sec_cnt = (s_r.sec_cnt >= 32'(SEC_CYC - 1)) ? 32'h0 : s_r.sec_cnt + 32'h1;
			unique case (s_r.phase)
				ST_IDLE: if (s_r.sec_cnt == 32'(SEC_CYC - PEND_CYC - UPD_CYC)) begin
					s_nxt.phase = ST_PEND;
					s_nxt.pend = 1'b1;
				end
				ST_PEND: if (s_r.sec_cnt == 32'(SEC_CYC - UPD_CYC)) begin
					s_nxt.phase = ST_UPD;
					s_nxt.upd_cnt = 32'h0;
					// advance the clock at the start of the window
					t.sec = bcd_inc(s_r.tm.sec, 8'h59, 8'h00, w0);
					if (w0)
						t.min = bcd_inc(s_r.tm.min, 8'h59, 8'h00, w1);
					if (w0 && w1) begin
						if (s_r.reg_b[`RTCR_BIT_H24]) begin
							t.hr = bcd_inc(s_r.tm.hr, 8'h23, 8'h00, w2);
						end else begin
							pm = s_r.tm.hr[`RTCR_BIT_PM];
							hv = bcd_inc({1'b0, s_r.tm.hr[6:0]}, 8'h12, 8'h01, w5);
							if (hv == 8'h12)
								pm = !pm;
							w2 = (hv == 8'h12) && pm == 1'b0;
							t.hr = {pm, hv[6:0]};
						end
					end
					if (w0 && w1 && w2) begin
						t.wday = bcd_inc(s_r.tm.wday, 8'h07, 8'h01, w5);
						t.date = bcd_inc(s_r.tm.date, month_end(s_r.tm.month, s_r.tm.year),
						                 8'h01, w3);
						if (w3)
							t.month = bcd_inc(s_r.tm.month, 8'h12, 8'h01, w4);
						if (w3 && w4)
							t.year = bcd_inc(s_r.tm.year, 8'h99, 8'h00, w5);
					end
					s_nxt.tm = t;
					if (al_match(s_r.sec_al, t.sec) && al_match(s_r.min_al, t.min)
					    && al_match(s_r.hr_al, t.hr)) begin
						s_nxt.alarm = 1'b1;
						s_nxt.reg_c[1] = 1'b1;
						flag_set[1] = 1'b1;
					end
					s_nxt.reg_c[0] = 1'b1;
					flag_set[0] = 1'b1;
				end
				ST_UPD: begin
					s_nxt.upd_cnt = s_r.upd_cnt + 32'h1;
					if (s_r.upd_cnt >= 32'(UPD_CYC - 1)) begin
						s_nxt.phase = ST_IDLE;
						s_nxt.pend = 1'b0;
					end
				end
				default: s_nxt.phase = ST_IDLE;
			endcase
		end

		// data port read
		if (i_io.rd && on_data) begin
			s_nxt.rvalid = 1'b1;
			if (refused) begin
				rd = `RTCR_NO_DATA;
			end else begin
				unique case (idx)
					`RTCR_IDX_SEC:    rd = {1'b0, s_r.tm.sec[6:0]};
					`RTCR_IDX_SEC_AL: rd = s_r.sec_al;
					`RTCR_IDX_MIN:    rd = s_r.tm.min;
					`RTCR_IDX_MIN_AL: rd = s_r.min_al;
					`RTCR_IDX_HR:     rd = s_r.tm.hr;
					`RTCR_IDX_HR_AL:  rd = s_r.hr_al;
					`RTCR_IDX_WDAY:   rd = s_r.tm.wday;
					`RTCR_IDX_DATE:   rd = s_r.tm.date;
					`RTCR_IDX_MONTH:  rd = s_r.tm.month;
					`RTCR_IDX_YEAR:   rd = s_r.tm.year;
					`RTCR_IDX_REG_A:  rd = {s_r.pend, s_r.reg_a};
					`RTCR_IDX_REG_B:  rd = s_r.reg_b;
					`RTCR_IDX_REG_C:  rd = {s_r.reg_c, 4'h0};
					`RTCR_IDX_REG_D:  rd = 8'h80;
					default:          rd = ram_r[idx];
				endcase
				// reading the flag register clears it; a same-cycle set still wins
				// the clear drops only old flags, so an event in the same cycle survives
				if (idx == `RTCR_IDX_REG_C)
					s_nxt.reg_c = flag_set;
			end
			s_nxt.rdata = rd;
		end

		// data port write; clock bytes closed during the update window
		if (i_io.wr && on_data && !refused
		    && !(is_clk_byte && s_r.phase == ST_UPD)) begin
			unique case (idx)
				`RTCR_IDX_SEC:    s_nxt.tm.sec = {1'b0, i_io.wdata[6:0]};
				`RTCR_IDX_SEC_AL: s_nxt.sec_al = i_io.wdata;
				`RTCR_IDX_MIN:    s_nxt.tm.min = i_io.wdata;
				`RTCR_IDX_MIN_AL: s_nxt.min_al = i_io.wdata;
				`RTCR_IDX_HR:     s_nxt.tm.hr = i_io.wdata;
				`RTCR_IDX_HR_AL:  s_nxt.hr_al = i_io.wdata;
				`RTCR_IDX_WDAY:   s_nxt.tm.wday = i_io.wdata;
				`RTCR_IDX_DATE:   s_nxt.tm.date = i_io.wdata;
				`RTCR_IDX_MONTH:  s_nxt.tm.month = i_io.wdata;
				`RTCR_IDX_YEAR:   s_nxt.tm.year = i_io.wdata;
				`RTCR_IDX_REG_A:  s_nxt.reg_a = i_io.wdata[6:0];
				`RTCR_IDX_REG_B: begin
					s_nxt.reg_b = i_io.wdata;
					if (i_io.wdata[`RTCR_BIT_HALT]) begin
						s_nxt.pend = 1'b0;
						s_nxt.phase = ST_IDLE;
					end
				end
				default: ; // c and d writes dropped, ram written elsewhere
			endcase
		end
		s_nxt.rst_sync = 2'h0;
	end

	// ram array written outside the state struct: no reset, as battery-backed storage
	always_ff @(posedge i_mclk) begin
		if (i_io.wr && i_io.addr == `RTCR_PORT_DATA && i_bus_master_n
		    && !(i_secure_area_lock && s_r.index >= `RTCR_IDX_SECURE_LO
		         && s_r.index <= `RTCR_IDX_SECURE_HI)
		    && s_r.index >= `RTCR_IDX_RAM_LO) begin
			ram_r[s_r.index] <= i_io.wdata;
		end
	end

	// state register; the divider and rate field is left out of reset on purpose,
	// so a board reset does not stop or retune the running divider
	// limitation: that field powers up unknown until software writes it once
	always_ff @(posedge i_mclk or negedge rstn_int) begin
		if (!rstn_int) begin
			s_r.rst_sync <= 2'h0;
			s_r.index <= 7'h00;
			s_r.tm <= '0;
			s_r.sec_al <= 8'h00;
			s_r.min_al <= 8'h00;
			s_r.hr_al <= 8'h00;
			s_r.reg_b <= 8'h00;
			s_r.reg_c <= 4'h0;
			s_r.phase <= ST_IDLE;
			s_r.sec_cnt <= 32'h0;
			s_r.upd_cnt <= 32'h0;
			s_r.pend <= 1'b0;
			s_r.rdata <= 8'h00;
			s_r.rvalid <= 1'b0;
			s_r.alarm <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// every output is a field of the registered state
	assign o_rdata = s_r.rdata;
	assign o_rvalid = s_r.rvalid;
	assign o_alarm = s_r.alarm;
	assign o_update_pending_flag = s_r.pend;
endmodule
`default_nettype wire

// *** rtcr_core_assertions.sv ***
// port-level checks for the clock and calendar register block
`timescale 1ns/1ps
`default_nettype none
module rtcr_chk (
	// clock and reset
	input wire logic               i_mclk,
	input wire logic               i_resetn,
	// host side
	input wire rtcr_pkg::rtcr_io_t i_io,
	input wire logic               i_bus_master_n,
	input wire logic               i_secure_area_lock,
	// answers
	input wire logic [7:0]         o_rdata,
	input wire logic               o_rvalid,
	input wire logic               o_alarm,
	input wire logic               o_update_pending_flag
);
	import rtcr_pkg::*;
	logic [6:0] idx_r;
	logic       rd_d;
	logic       wr_d;
	// shadow of the index; the index port itself is not blocked by the bus master
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			idx_r <= 7'h00;
		else if (i_io.wr && i_io.addr == 10'h070)
			idx_r <= i_io.wdata[6:0];
	end
	// data port strobes
	assign rd_d = i_io.rd && i_io.addr == 10'h071;
	assign wr_d = i_io.wr && i_io.addr == 10'h071;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	rd_answer_a: assert property (rd_d |=> o_rvalid)
		else $error("read not answered");
	rvalid_cause_a: assert property (o_rvalid |-> $past(rd_d))
		else $error("read data without read");
	master_block_a: assert property (rd_d && !i_bus_master_n |=> o_rdata == 8'hff)
		else $error("read passed while bus master active");
	secure_block_a: assert property (rd_d && i_secure_area_lock && idx_r[6:3] == 4'h7
		|=> o_rdata == 8'hff)
		else $error("secure byte readable under lock");
	regd_fixed_a: assert property (rd_d && i_bus_master_n && idx_r == 7'h0d
		|=> o_rdata == 8'h80)
		else $error("register d reads wrong");
	sec_top_zero_a: assert property (rd_d && i_bus_master_n && idx_r == 7'h00
		&& !o_update_pending_flag |=> !o_rdata[7])
		else $error("seconds bit 7 not zero");
	halt_clear_a: assert property (wr_d && i_bus_master_n && idx_r == 7'h0b && i_io.wdata[7]
		|-> ##[1:2] !o_update_pending_flag)
		else $error("halt did not clear pending");
	pend_hold_a: assert property ($rose(o_update_pending_flag) ##1 (!wr_d)[*4]
		|-> o_update_pending_flag)
		else $error("pending dropped early");
	alarm_pulse_a: assert property (o_alarm |-> o_update_pending_flag ##1 !o_alarm)
		else $error("alarm outside update");
	cover property (o_alarm);
	cover property ($rose(o_update_pending_flag));
	cover property (rd_d && !i_bus_master_n);
endmodule
`default_nettype wire

// *** rtcr_host.sv ***
// host model driving the index and data port pair
`timescale 1ns/1ps
`default_nettype none
module rtcr_host (
	// clock and answers
	input wire logic           i_mclk,
	input wire logic [7:0]     i_rdata,
	input wire logic           i_rvalid,
	// port cycle
	output var rtcr_pkg::rtcr_io_t o_io
);
	import rtcr_pkg::*;
	initial o_io = '0;
	// one strobe cycle; released lines show the inverse, not the old value
	task automatic cyc(input logic [9:0] a, input logic [7:0] d, input logic w);
		@(posedge i_mclk);
		#2;
		o_io = '{a, d, w, !w};
		@(posedge i_mclk);
		#2;
		o_io = '{~a, ~d, 1'b0, 1'b0};
	endtask
	// index first, then the data port
	task automatic sel(input logic [6:0] i);
		cyc(10'h070, {1'b0, i}, 1'b1);
	endtask
	// read data is taken in the cycle the answer stands
	task automatic rdat(output logic [7:0] d);
		cyc(10'h071, 8'h00, 1'b0);
		d = i_rvalid ? i_rdata : 8'hxx;
	endtask
	task automatic wr_reg(input logic [6:0] i, input logic [7:0] d);
		sel(i);
		cyc(10'h071, d, 1'b1);
	endtask
	task automatic rd_reg(input logic [6:0] i, output logic [7:0] d);
		sel(i);
		rdat(d);
	endtask
endmodule
`default_nettype wire

// *** rtcr_core_tb.sv ***
// self-checking bench for the clock and calendar register block
`timescale 1ns/1ps
`default_nettype none
module rtcr_core_tb;
	import rtcr_pkg::*;
	logic       i_mclk = 1'b0;
	logic       i_resetn = 1'b0;
	logic       bm_n = 1'b1;
	logic       lock = 1'b0;
	logic       seen = 1'b0;
	rtcr_io_t   io;
	logic [7:0] rdata;
	logic [7:0] d;
	logic       rvalid;
	logic       alarm;
	logic       pend;
	logic [47:0] r;
	int         n_errors = 0;
	int         checks = 0;
	logic [47:0] rows [4] = '{48'h311299010100, 48'h280204290204,
		48'h290204010304, 48'h300405010505};
	logic [7:0] ld [7] = '{8'hd9, 8'hc0, 8'h59, 8'hc0, 8'h23, 8'hc0, 8'h07};
	always #12.5 i_mclk = ~i_mclk;
	// short counts so a second lasts 200 cycles
	rtcr_core #(.SEC_CYC(200), .UPD_CYC(20), .PEND_CYC(10)) rtcr_core_inst (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .i_io(io), .i_bus_master_n(bm_n),
		.i_secure_area_lock(lock), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_alarm(alarm), .o_update_pending_flag(pend));
	rtcr_host rtcr_host_inst (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_io(io));
	// alarm is a one-cycle pulse, so latch it
	always @(posedge i_mclk) if (alarm === 1'b1) seen <= 1'b1;
	task automatic conclude();
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] i, input logic [7:0] v);
		rtcr_host_inst.wr_reg(i, v);
	endtask
	task automatic rc(input logic [6:0] i, input logic [7:0] e);
		logic [7:0] v;
		rtcr_host_inst.rd_reg(i, v);
		chk(v, e);
	endtask
	// bounded wait for the pending flag to reach a level
	task automatic waitp(input logic v);
		int n;
		n = 0;
		while (pend !== v && n < 400) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		chk({7'h0, pend}, {7'h0, v});
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge i_mclk);
		#2 i_resetn = 1'b1;
		repeat (3) @(posedge i_mclk);
		wr(7'h0b, 8'h82);
		wr(7'h0e, 8'h5a);
		wr(7'h7f, 8'ha5);
		wr(7'h0d, 8'h00);
		wr(7'h0a, 8'ha2);
		rc(7'h0e, 8'h5a);
		rc(7'h7f, 8'ha5);
		rc(7'h0d, 8'h80);
		rc(7'h0a, 8'h22);
		repeat (300) @(posedge i_mclk);
		chk({7'h0, pend}, 8'h00);
		for (int k = 0; k < 4; k++) begin
			r = rows[k];
			wr(7'h0b, 8'h82);
			for (int j = 0; j < 7; j++) wr(j[6:0], ld[j]);
			wr(7'h07, r[47:40]);
			wr(7'h08, r[39:32]);
			wr(7'h09, r[31:24]);
			rc(7'h00, 8'h59);
			seen = 1'b0;
			wr(7'h0b, 8'h02);
			waitp(1'b1);
			if (k == 3) begin
				rc(7'h0b, 8'h02);
				wr(7'h0e, 8'h3c);
				rc(7'h0e, 8'h3c);
				wr(7'h03, 8'h11);
			end
			waitp(1'b0);
			for (int j = 0; j < 6; j += 2) rc(j[6:0], 8'h00);
			rc(7'h06, 8'h01);
			rc(7'h07, r[23:16]);
			rc(7'h08, r[15:8]);
			rc(7'h09, r[7:0]);
			rc(7'h03, 8'hc0);
			chk({7'h0, seen}, 8'h01);
		end
		// 12-hour form, exact alarm at one pm
		wr(7'h0b, 8'h80);
		wr(7'h00, 8'h59);
		wr(7'h02, 8'h59);
		wr(7'h04, 8'h92);
		wr(7'h01, 8'h00);
		wr(7'h03, 8'h00);
		wr(7'h05, 8'h81);
		seen = 1'b0;
		wr(7'h0b, 8'h00);
		waitp(1'b1);
		waitp(1'b0);
		rc(7'h04, 8'h81);
		chk({7'h0, seen}, 8'h01);
		waitp(1'b1);
		wr(7'h0b, 8'h80);
		chk({7'h0, pend}, 8'h00);
		// secure area and bus master refusal
		wr(7'h38, 8'h77);
		wr(7'h37, 8'h66);
		lock = 1'b1;
		wr(7'h38, 8'h11);
		rc(7'h38, 8'hff);
		rc(7'h37, 8'h66);
		lock = 1'b0;
		rc(7'h38, 8'h77);
		rtcr_host_inst.sel(7'h0e);
		bm_n = 1'b0;
		rtcr_host_inst.cyc(10'h071, 8'haa, 1'b1);
		rtcr_host_inst.rdat(d);
		chk(d, 8'hff);
		bm_n = 1'b1;
		rtcr_host_inst.rdat(d);
		chk(d, 8'h3c);
		conclude();
	end
	// watchdog
	initial begin
		#(12000 * 25);
		n_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		conclude();
	end
endmodule
bind rtcr_core rtcr_chk rtcr_chk_inst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_io(i_io),
	.i_bus_master_n(i_bus_master_n), .i_secure_area_lock(i_secure_area_lock),
	.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_alarm(o_alarm),
	.o_update_pending_flag(o_update_pending_flag));
`default_nettype wire
